// file: bkpt_defines.vh
// ==========================================================================
// Port map and field constants for the breakpoint and PC trace ports
// ==========================================================================
`ifndef BKPT_DEFINES_VH
`define BKPT_DEFINES_VH

// I/O port addresses
`define PORT_PENDING      8'hf2
`define PORT_DEBUG_CTRL   8'hf8
`define PORT_FIRST_EXT    8'hf6
`define PORT_SECOND_EXT   8'hf7
`define PORT_FIRST_LOW    8'hfc
`define PORT_FIRST_HIGH   8'hfd
`define PORT_SECOND_LOW   8'hfe
`define PORT_SECOND_HIGH  8'hff

// Debug control byte fields (stored as on the bus, active zero)
`define CTRL_FIRST_RD     0
`define CTRL_FIRST_WR     1
`define CTRL_SECOND_RD    2
`define CTRL_SECOND_WR    3
`define CTRL_WIDTH        5

// Pending register bit positions
`define PEND_SECOND       6
`define PEND_FIRST        7

// Reset values
`define BYTE_RESET        8'h00
`define CTRL_RESET        5'h1f
`define ADDR_RESET        24'h000000

`endif

// file: addr_match.v
`timescale 1ns/1ps
`include "bkpt_defines.vh"

// ==========================================================================
// Breakpoint address comparator
// ==========================================================================
module addr_match (
   // Stored breakpoint bytes
   input  wire [7:0]  ext_byte,
   input  wire [7:0]  high_byte,
   input  wire [7:0]  low_byte,
   // Program address under test
   input  wire [23:0] prog_addr,
   // Result
   output wire        hit
);

   // All three bytes must agree with the same address
   assign hit = (ext_byte  == prog_addr[23:16]) &&
                (high_byte == prog_addr[15:8])  &&
                (low_byte  == prog_addr[7:0]);

endmodule // addr_match

// file: breakpoint_pc_trace_ports.v
// Overview of operation
// - Write to port FD loads first breakpoint high byte, data bits are address 8-15.
// - First high byte compared with program address high byte; match raises first interrupt.
// - Read of FD pulses next-PC high strobe low, returns next PC high byte.
// - Write to FE loads second low byte; match with address low byte interrupts.
// - Write to FF loads second high byte; match with address high byte interrupts.
// - Read of FE pulses last-PC low strobe low, returns last PC low byte.
// - Read of FF pulses last-PC high strobe low, returns last PC high byte.
// - Pending register at F2: bit 6 second breakpoint, bit 7 first.
// - Complemented control byte at F8 enables each breakpoint per read or write.
`timescale 1ns/1ps
`include "bkpt_defines.vh"

module breakpoint_pc_trace_ports (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        clk_en,
   // System processor I/O port bus
   input  wire [7:0]  io_addr,
   input  wire        io_wr,
   input  wire        io_rd,
   input  wire [7:0]  io_wdata,
   input  wire        pend_clear,
   output reg  [7:0]  io_rdata,
   output reg         io_rvalid,
   // Emulated program cycles
   input  wire        prog_valid,
   input  wire        prog_is_write,
   input  wire [23:0] prog_addr,
   input  wire        prog_fetch,
   // Trace strobes, active low
   output reg         next_pc_high_strobe_n,
   output reg         last_pc_low_strobe_n,
   output reg         last_pc_high_strobe_n,
   // Breakpoint events and pending flags
   output reg         first_breakpoint,
   output reg         second_breakpoint,
   output reg  [7:0]  pending
);

   // =======================================================================
   // Storage
   // =======================================================================
   // Breakpoint 1 bytes, held in true form
   reg  [7:0]  first_ext;
   reg  [7:0]  first_break_low_byte;
   reg  [7:0]  first_break_high_byte;
   // Breakpoint 2 bytes, held in true form
   reg  [7:0]  second_ext;
   reg  [7:0]  second_break_low_byte;
   reg  [7:0]  second_break_high_byte;
   // Access enables and trace registers
   reg  [4:0]  debug_ctrl;
   reg  [23:0] next_pc_bits;
   reg  [23:0] last_pc_bits;
   reg  [7:0]  next_rdata;
   // Comparator results and qualified matches
   wire        first_hit;
   wire        second_hit;
   wire        first_arm;
   wire        second_arm;
   wire        first_event;
   wire        second_event;

   // Bus byte arrives complemented; invert once here
   function [7:0] true_byte;
      input [7:0] bus_byte;
      begin
         true_byte = ~bus_byte;
      end
   endfunction

   // Select the read or write enable of one breakpoint; a stored one disarms
   function arm_for;
      input is_write;
      input rd_off;
      input wr_off;
      begin
         arm_for = is_write ? ~wr_off : ~rd_off;
      end
   endfunction

   // Read aimed at one port; decoded alike for all three strobes
   function port_read;
      input       rd;
      input [7:0] addr;
      input [7:0] port;
      begin
         port_read = rd && (addr == port);
      end
   endfunction

   // =======================================================================
   // Comparators
   // =======================================================================
   addr_match u_first (
      .ext_byte  (first_ext),
      .high_byte (first_break_high_byte),
      .low_byte  (first_break_low_byte),
      .prog_addr (prog_addr),
      .hit       (first_hit)
   );

   addr_match u_second (
      .ext_byte  (second_ext),
      .high_byte (second_break_high_byte),
      .low_byte  (second_break_low_byte),
      .prog_addr (prog_addr),
      .hit       (second_hit)
   );

   // Access type gating; the enable is picked per cycle, not latched
   assign first_arm  = arm_for(prog_is_write, debug_ctrl[`CTRL_FIRST_RD],
                               debug_ctrl[`CTRL_FIRST_WR]);
   assign second_arm = arm_for(prog_is_write, debug_ctrl[`CTRL_SECOND_RD],
                               debug_ctrl[`CTRL_SECOND_WR]);

   // A match counts only on a valid program cycle of an enabled type
   assign first_event  = prog_valid && first_arm && first_hit;
   assign second_event = prog_valid && second_arm && second_hit;

   // =======================================================================
   // Register writes
   // =======================================================================
   // Write-only bytes; breakpoint bytes stored in true form for a direct compare, control byte as on the bus
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         first_ext              <= `BYTE_RESET;
         first_break_low_byte   <= `BYTE_RESET;
         first_break_high_byte  <= `BYTE_RESET;
         second_ext             <= `BYTE_RESET;
         second_break_low_byte  <= `BYTE_RESET;
         second_break_high_byte <= `BYTE_RESET;
         debug_ctrl             <= `CTRL_RESET;
      end else if (clk_en && io_wr) begin
         case (io_addr)
            `PORT_FIRST_EXT:   first_ext <= true_byte(io_wdata);
            `PORT_FIRST_LOW:   first_break_low_byte <= true_byte(io_wdata);
            `PORT_FIRST_HIGH:  first_break_high_byte <= true_byte(io_wdata);
            `PORT_SECOND_EXT:  second_ext <= true_byte(io_wdata);
            `PORT_SECOND_LOW:  second_break_low_byte <= true_byte(io_wdata);
            `PORT_SECOND_HIGH: second_break_high_byte <= true_byte(io_wdata);
            // Complemented on the bus, so the stored bit is zero to enable
            `PORT_DEBUG_CTRL:  debug_ctrl <= io_wdata[`CTRL_WIDTH-1:0];
            default:           debug_ctrl <= debug_ctrl;
         endcase
      end
   end

   // =======================================================================
   // PC capture
   // =======================================================================
   // Fetch address becomes next; previous next becomes last
   // Only fetches move the trace, so data cycles do not disturb it
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         next_pc_bits <= `ADDR_RESET;
         last_pc_bits <= `ADDR_RESET;
      end else if (clk_en && prog_valid && prog_fetch) begin
         last_pc_bits <= next_pc_bits;
         next_pc_bits <= prog_addr;
      end
   end

   // =======================================================================
   // Breakpoint detection and pending flags
   // =======================================================================
   // Event pulses last one cycle; pending holds until cleared, set wins
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         first_breakpoint  <= 1'b0;
         second_breakpoint <= 1'b0;
         pending           <= `BYTE_RESET;
      end else if (clk_en) begin
         first_breakpoint  <= first_event;
         second_breakpoint <= second_event;
         // A hit in the clear cycle survives, so no match is ever lost
         if (pend_clear) begin
            pending[`PEND_FIRST]  <= 1'b0;
            pending[`PEND_SECOND] <= 1'b0;
         end
         if (first_event)
            pending[`PEND_FIRST] <= 1'b1;
         if (second_event)
            pending[`PEND_SECOND] <= 1'b1;
      end
   end

   // =======================================================================
   // Read path and strobes
   // =======================================================================
   // Read data select; unmapped ports read zero
   // Extended ports and port FC answer here too but raise no strobe
   always @* begin
      case (io_addr)
         `PORT_PENDING:     next_rdata = pending;
         `PORT_FIRST_EXT:   next_rdata = next_pc_bits[23:16];
         `PORT_FIRST_LOW:   next_rdata = next_pc_bits[7:0];
         `PORT_FIRST_HIGH:  next_rdata = next_pc_bits[15:8];
         `PORT_SECOND_EXT:  next_rdata = last_pc_bits[23:16];
         `PORT_SECOND_LOW:  next_rdata = last_pc_bits[7:0];
         `PORT_SECOND_HIGH: next_rdata = last_pc_bits[15:8];
         default:           next_rdata = `BYTE_RESET;
      endcase
   end

   // Strobes pulse low for one cycle with the data
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata              <= `BYTE_RESET;
         io_rvalid             <= 1'b0;
         next_pc_high_strobe_n <= 1'b1;
         last_pc_low_strobe_n  <= 1'b1;
         last_pc_high_strobe_n <= 1'b1;
      end else if (clk_en) begin
         io_rvalid             <= io_rd;
         io_rdata              <= io_rd ? next_rdata : `BYTE_RESET;
         next_pc_high_strobe_n <= ~port_read(io_rd, io_addr, `PORT_FIRST_HIGH);
         last_pc_low_strobe_n  <= ~port_read(io_rd, io_addr, `PORT_SECOND_LOW);
         last_pc_high_strobe_n <= ~port_read(io_rd, io_addr, `PORT_SECOND_HIGH);
      end
   end

endmodule // breakpoint_pc_trace_ports

// file: breakpoint_pc_trace_ports_sva.sv
`timescale 1ns/1ps
// ==========
// Port timing checks
module bkpt_ports_chk (
   // Watched ports
   input wire       clk_sys,
   input wire       rst_n,
   input wire       clk_en,
   input wire       io_rd,
   input wire [7:0] io_addr,
   input wire       prog_valid,
   input wire       io_rvalid,
   input wire       next_pc_high_strobe_n,
   input wire       last_pc_low_strobe_n,
   input wire       last_pc_high_strobe_n,
   input wire       first_breakpoint,
   input wire       second_breakpoint,
   input wire [7:0] pending
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Taken read this edge
   wire rd_ok = io_rd && clk_en;
   a_next_hi_strobe: assert property (rd_ok && io_addr == 8'hfd |=> !next_pc_high_strobe_n)
      else $error("next pc high strobe missing");
   a_last_lo_strobe: assert property (rd_ok && io_addr == 8'hfe |=> !last_pc_low_strobe_n)
      else $error("last pc low strobe missing");
   a_last_hi_strobe: assert property (rd_ok && io_addr == 8'hff |=> !last_pc_high_strobe_n)
      else $error("last pc high strobe missing");
   a_read_answer: assert property (rd_ok |=> io_rvalid)
      else $error("read answer missing");
   a_read_idle: assert property (clk_en && !io_rd |=> !io_rvalid)
      else $error("read answer without request");
   a_first_pend: assert property (first_breakpoint |-> pending[7])
      else $error("first pending flag missing");
   a_second_pend: assert property (second_breakpoint |-> pending[6])
      else $error("second pending flag missing");
   a_pend_spare: assert property (pending[5:0] == 6'h00)
      else $error("spare pending bits set");
   a_first_cause: assert property ($rose(first_breakpoint) |-> $past(prog_valid && clk_en))
      else $error("first hit without program cycle");
   a_second_cause: assert property ($rose(second_breakpoint) |-> $past(prog_valid && clk_en))
      else $error("second hit without program cycle");
   c_first: cover property (first_breakpoint);
   c_second: cover property (second_breakpoint);
   c_read: cover property (io_rvalid);
endmodule // bkpt_ports_chk
bind breakpoint_pc_trace_ports bkpt_ports_chk u_bkpt_ports_chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .clk_en(clk_en), .io_rd(io_rd), .io_addr(io_addr), .prog_valid(prog_valid),
   .io_rvalid(io_rvalid), .next_pc_high_strobe_n(next_pc_high_strobe_n),
   .last_pc_low_strobe_n(last_pc_low_strobe_n), .last_pc_high_strobe_n(last_pc_high_strobe_n),
   .first_breakpoint(first_breakpoint), .second_breakpoint(second_breakpoint),
   .pending(pending));

// file: io_host_model.sv
`timescale 1ns/1ps
// ==========
// System processor on the port bus
module io_host_model (
   // Bus
   input  wire       clk_sys,
   input  wire [7:0] io_rdata,
   input  wire       io_rvalid,
   output logic [7:0] io_addr,
   output logic       io_wr,
   output logic       io_rd,
   output logic [7:0] io_wdata
);
   initial begin
      io_addr = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // Value v is the true byte; bus carries it inverted
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      io_addr = a;
      io_wdata = ~v;
      io_wr = 1'b1;
      @(negedge clk_sys);
      io_wr = 1'b0;
      io_wdata = v; // Stale byte must not look valid
   endtask
   // Answer lands one edge after the request
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk_sys);
      io_rd = 1'b0;
      io_addr = ~a;
      d = io_rvalid ? io_rdata : 8'hxx; // Data counts only with its valid
   endtask
endmodule // io_host_model

// file: breakpoint_pc_trace_ports_tb.sv
`timescale 1ns/1ps
// ==========
// Bench top
module breakpoint_pc_trace_ports_tb;
   logic        clk_sys, rst_n, clk_en, pend_clear, prog_valid, prog_is_write, prog_fetch;
   logic [23:0] prog_addr;
   logic [7:0]  d;
   wire  [7:0]  io_addr, io_wdata, io_rdata, pending;
   wire         io_wr, io_rd, io_rvalid, nh_n, ll_n, lh_n, bp1, bp2;
   int          errors = 0;
   int          compares = 0;
   breakpoint_pc_trace_ports u_breakpoint_pc_trace_ports (.clk_sys(clk_sys), .rst_n(rst_n),
      .clk_en(clk_en), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .pend_clear(pend_clear), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .prog_valid(prog_valid), .prog_is_write(prog_is_write), .prog_addr(prog_addr),
      .prog_fetch(prog_fetch), .next_pc_high_strobe_n(nh_n), .last_pc_low_strobe_n(ll_n),
      .last_pc_high_strobe_n(lh_n), .first_breakpoint(bp1), .second_breakpoint(bp2),
      .pending(pending));
   io_host_model u_io_host_model (.clk_sys(clk_sys), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // One program cycle, then look at the event pulses
   task automatic cyc(input logic [23:0] a, input logic w, input logic e1, input logic e2);
      @(negedge clk_sys);
      prog_valid = 1'b1;
      prog_is_write = w;
      prog_fetch = !w;
      prog_addr = a;
      @(negedge clk_sys);
      prog_valid = 1'b0;
      prog_fetch = 1'b0;
      prog_addr = ~a;
      chk("first_breakpoint", {7'h00, e1}, {7'h00, bp1});
      chk("second_breakpoint", {7'h00, e2}, {7'h00, bp2});
   endtask
   task automatic finish_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #20000;
      errors++;
      finish_test;
   end
   // Main sequence
   initial begin
      {rst_n, clk_en, pend_clear, prog_valid, prog_is_write, prog_fetch} = 6'b010000;
      prog_addr = 24'h000000;
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      u_io_host_model.wr(8'hf6, 8'h00);
      u_io_host_model.wr(8'hfd, 8'h12);
      u_io_host_model.wr(8'hfc, 8'h34);
      u_io_host_model.wr(8'hf7, 8'h00);
      u_io_host_model.wr(8'hff, 8'h56);
      u_io_host_model.wr(8'hfe, 8'h78);
      u_io_host_model.wr(8'hf8, 8'hff);
      cyc(24'h001234, 1'b0, 1'b1, 1'b0);
      cyc(24'h005678, 1'b0, 1'b0, 1'b1);
      cyc(24'h011234, 1'b0, 1'b0, 1'b0);
      chk("pending", 8'hc0, pending);
      $display("test hits done");
      u_io_host_model.rd(8'hfd, d);
      chk("next_pc_high_byte", 8'h12, d);
      u_io_host_model.rd(8'hfe, d);
      chk("last_pc_low_byte", 8'h78, d);
      u_io_host_model.rd(8'hff, d);
      chk("last_pc_high_byte", 8'h56, d);
      u_io_host_model.rd(8'h10, d);
      chk("unmapped", 8'h00, d);
      u_io_host_model.rd(8'hf2, d);
      chk("pending_port", 8'hc0, d);
      u_io_host_model.rd(8'hfc, d);
      chk("next_pc_low_byte", 8'h34, d);
      u_io_host_model.rd(8'hf6, d);
      chk("next_pc_ext_byte", 8'h01, d);
      $display("test reads done");
      @(negedge clk_sys) pend_clear = 1'b1;
      @(negedge clk_sys) pend_clear = 1'b0;
      chk("pending", 8'h00, pending);
      u_io_host_model.wr(8'hf8, 8'hfe);
      cyc(24'h001234, 1'b0, 1'b0, 1'b0);
      cyc(24'h001234, 1'b1, 1'b1, 1'b0);
      u_io_host_model.wr(8'hf8, 8'hf7);
      cyc(24'h005678, 1'b1, 1'b0, 1'b0);
      cyc(24'h005678, 1'b0, 1'b0, 1'b1);
      $display("test enables done");
      // Mid-run reset clears the bytes and disarms both breakpoints
      @(negedge clk_sys) rst_n = 1'b0;
      @(negedge clk_sys) rst_n = 1'b1;
      chk("pending", 8'h00, pending);
      cyc(24'h000000, 1'b1, 1'b0, 1'b0);
      u_io_host_model.rd(8'hfd, d);
      chk("next_pc_high_byte", 8'h00, d);
      $display("test reset done");
      finish_test;
   end
endmodule // breakpoint_pc_trace_ports_tb
